// ### hdl/tmdsrx_pkg.sv
// Package: shared types and constants of the receiver pixel output block
package tmdsrx_pkg;
   // ==================================================
   // Carriers
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } tmdsrx_pix_t;
   typedef struct packed {
      logic de;
      logic vsync;
      logic hsync;
      logic aux_b;
      logic aux_a;
   } tmdsrx_ctl_t;
   typedef enum logic {
      TMDSRX_OCK_LO = 1'b0,
      TMDSRX_OCK_HI = 1'b1
   } tmdsrx_ock_t;
   // ==================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned LINK_TMO_NS = 100000;
   localparam int unsigned LINK_TMO_CYC = LINK_TMO_NS / CLK_PERIOD_NS;
   localparam int unsigned OCK_LOW_NS = 400;
   localparam int unsigned OCK_LOW_CYC = (OCK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STAGGER_SEL_N_LAG_NS = 200;
   localparam int unsigned STAGGER_SEL_N_LAG_CYC = STAGGER_SEL_N_LAG_NS / CLK_PERIOD_NS;
   // ==================================================
   // Registers
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic CTRL_RST = 1'b0;
   localparam int unsigned CTRL_SOFT_OFF_BIT = 0;
   localparam int unsigned STATUS_LINK_BIT = 0;
   localparam int unsigned STATUS_DUAL_BIT = 1;
   localparam int unsigned STATUS_STAGGER_SEL_N_BIT = 2;
   localparam int unsigned STATUS_PHASE_BIT = 3;
   localparam int unsigned STATUS_RESERVED_PIN_BIT = 4;
endpackage

// ### hdl/tmdsrx_pixel_output.sv
// Module: pixel output stage of the receiver with link detect and register slave
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tmdsrx_pixel_output #(
   parameter int unsigned LINK_TMO = tmdsrx_pkg::LINK_TMO_CYC
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Link side, decoded lanes
   input wire logic i_link_clk_in,
   input wire logic [7:0] i_lane0_in,
   input wire logic [7:0] i_lane1_in,
   input wire logic [7:0] i_lane2_in,
   input wire logic i_video_active_en,
   // Mode and power pins
   input wire logic i_pixels_per_clk_sel,
   input wire logic i_stagger_sel_n,
   input wire logic i_out_drive_pwrdn_n,
   input wire logic i_chip_pwrdn_n,
   input wire logic i_reserved_pin,
   // Pixel outputs
   output tmdsrx_pkg::tmdsrx_pix_t o_even_pixel_bus,
   output tmdsrx_pkg::tmdsrx_pix_t o_odd_pixel_bus,
   output tmdsrx_pkg::tmdsrx_ctl_t o_ctl,
   output logic o_out_pixel_clk,
   output logic o_link_detect,
   // Output enables
   output logic o_pix_oe,
   output logic o_aux_ctrl_a_oe,
   output logic o_link_detect_oe,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   localparam int SW = 31;
   localparam int TW = $clog2(LINK_TMO + 1);
   localparam int LAG = tmdsrx_pkg::STAGGER_SEL_N_LAG_CYC;

   // ==================================================
   // Input synchronisers
   logic [SW-1:0] raw, s1_q, s2_q;
   logic lclk_d_q, de_d_q;
   logic lclk_s, de_s, pixels_per_clk_sel_s, stagger_sel_n_n_s, pdo_s, pd_s, reserved_pin_s;
   logic [7:0] lane0_s, lane1_s, lane2_s;
   assign raw = {i_link_clk_in, i_video_active_en, i_lane2_in, i_lane1_in, i_lane0_in,
                 i_pixels_per_clk_sel, i_stagger_sel_n, i_out_drive_pwrdn_n, i_chip_pwrdn_n, i_reserved_pin};
   // Two stages for every pin; only the second stage is read
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   assign lclk_s = s2_q[30];
   assign de_s = s2_q[29];
   assign lane2_s = s2_q[28:21];
   assign lane1_s = s2_q[20:13];
   assign lane0_s = s2_q[12:5];
   assign pixels_per_clk_sel_s = s2_q[4];
   assign stagger_sel_n_n_s = s2_q[3];
   assign pdo_s = s2_q[2];
   assign pd_s = s2_q[1];
   assign reserved_pin_s = s2_q[0];
   // Edge history of link clock and data enable
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         lclk_d_q <= 1'b0;
         de_d_q <= 1'b0;
      end else begin
         lclk_d_q <= lclk_s;
         de_d_q <= de_s;
      end
   end

   // ==================================================
   // Pixel capture and mode
   logic cap, dual, stagger_sel_n_on, upd, odd_ld, phase_q, de_edge;
   tmdsrx_pkg::tmdsrx_pix_t lane_pix, even_hold_q, odd_keep_q, odd_src, even_q, odd_q;
   logic [LAG-1:0] upd_dly_q;
   // Capture on the link clock falling edge: data sit mid-period, far from their change
   assign cap = lclk_d_q & ~lclk_s;
   assign dual = pixels_per_clk_sel_s;
   assign stagger_sel_n_on = dual & ~stagger_sel_n_n_s;
   assign lane_pix = {lane2_s, lane1_s, lane0_s};
   assign upd = cap & (~dual | ~de_s | phase_q);
   assign odd_src = de_s ? lane_pix : '0;
   assign de_edge = de_s ^ de_d_q;
   // Pixel parity restarts at zero in each blanking gap
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_q <= 1'b0;
      end else if (cap) begin
         phase_q <= de_s ? ~phase_q : 1'b0;
      end
   end
   // Even pixel parked until its odd partner arrives
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         even_hold_q <= '0;
      end else if (cap & dual & de_s & ~phase_q) begin
         even_hold_q <= lane_pix;
      end
   end
   // Even bus: every pixel in single mode, parked even pixel in dual mode
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         even_q <= '0;
      end else if (upd) begin
         if (!de_s) begin
            even_q <= '0;
         end else if (dual) begin
            even_q <= even_hold_q;
         end else begin
            even_q <= lane_pix;
         end
      end
   end
   // Stagger delay line; the lag stays under the clock low time so data settle first
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         upd_dly_q <= '0;
         odd_keep_q <= '0;
      end else begin
         upd_dly_q <= {upd_dly_q[LAG-2:0], upd};
         if (upd) begin
            odd_keep_q <= odd_src;
         end
      end
   end
   assign odd_ld = stagger_sel_n_on ? upd_dly_q[LAG-1] : upd;
   // Odd bus is forced low whenever single mode is chosen
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         odd_q <= '0;
      end else if (!dual) begin
         odd_q <= '0;
      end else if (odd_ld) begin
         odd_q <= stagger_sel_n_on ? odd_keep_q : odd_src;
      end
   end
   assign o_even_pixel_bus = even_q;
   assign o_odd_pixel_bus = odd_q;

   // ==================================================
   // Control outputs; syncs hold their last blanking value through active video
   tmdsrx_pkg::tmdsrx_ctl_t ctl_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_q <= '0;
      end else if (upd) begin
         ctl_q.de <= de_s;
         if (!de_s) begin
            ctl_q.hsync <= lane0_s[0];
            ctl_q.vsync <= lane0_s[1];
            ctl_q.aux_a <= lane1_s[0];
            ctl_q.aux_b <= lane2_s[0];
         end
      end
   end
   assign o_ctl = ctl_q;

   // ==================================================
   // Output pixel clock: falls with each update, rises after the low time
   tmdsrx_pkg::tmdsrx_ock_t ock_q;
   logic [2:0] ock_cnt_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ock_q <= tmdsrx_pkg::TMDSRX_OCK_HI;
         ock_cnt_q <= '0;
      end else if (upd) begin
         ock_q <= tmdsrx_pkg::TMDSRX_OCK_LO;
         ock_cnt_q <= '0;
      end else begin
         case (ock_q)
            tmdsrx_pkg::TMDSRX_OCK_LO: begin
               if (ock_cnt_q == 3'(tmdsrx_pkg::OCK_LOW_CYC - 1)) begin
                  ock_q <= tmdsrx_pkg::TMDSRX_OCK_HI;
               end else begin
                  ock_cnt_q <= ock_cnt_q + 3'h1;
               end
            end
            default: begin
               ock_q <= tmdsrx_pkg::TMDSRX_OCK_HI;
            end
         endcase
      end
   end
   assign o_out_pixel_clk = (ock_q == tmdsrx_pkg::TMDSRX_OCK_HI);

   // ==================================================
   // Link detect from data enable activity
   logic link_q;
   logic [TW-1:0] link_cnt_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         link_q <= 1'b0;
         link_cnt_q <= '0;
      end else if (de_edge) begin
         link_q <= 1'b1;
         link_cnt_q <= '0;
      end else if (link_cnt_q == TW'(LINK_TMO - 1)) begin
         link_q <= 1'b0;
      end else begin
         link_cnt_q <= link_cnt_q + 1'b1;
      end
   end
   assign o_link_detect = link_q;

   // ==================================================
   // Register slave, one wait state on every access
   logic ctrl_soft_off_q, ack_q, req;
   logic [31:0] rdata_q;
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end
   // Read data latched in the wait cycle, unmapped addresses read zero
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= '0;
      end else if (i_avs_read & ~ack_q) begin
         rdata_q <= '0;
         if (i_avs_address == tmdsrx_pkg::CTRL_OFS) begin
            rdata_q[tmdsrx_pkg::CTRL_SOFT_OFF_BIT] <= ctrl_soft_off_q;
         end else if (i_avs_address == tmdsrx_pkg::STATUS_OFS) begin
            rdata_q[tmdsrx_pkg::STATUS_LINK_BIT] <= link_q;
            rdata_q[tmdsrx_pkg::STATUS_DUAL_BIT] <= dual;
            rdata_q[tmdsrx_pkg::STATUS_STAGGER_SEL_N_BIT] <= stagger_sel_n_on;
            rdata_q[tmdsrx_pkg::STATUS_PHASE_BIT] <= phase_q;
            rdata_q[tmdsrx_pkg::STATUS_RESERVED_PIN_BIT] <= reserved_pin_s;
         end
      end
   end
   assign o_avs_readdata = rdata_q;
   // Write lands on the edge after the wait state, when waitrequest is low
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_soft_off_q <= tmdsrx_pkg::CTRL_RST;
      end else if (i_avs_write & ack_q & i_avs_byteenable[0] & (i_avs_address == tmdsrx_pkg::CTRL_OFS)) begin
         ctrl_soft_off_q <= i_avs_writedata[tmdsrx_pkg::CTRL_SOFT_OFF_BIT];
      end
   end

   // ==================================================
   // Output enables; link detect and aux a keep driving through output power-down
   logic pix_oe_q, keep_oe_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pix_oe_q <= 1'b0;
         keep_oe_q <= 1'b0;
      end else begin
         pix_oe_q <= pdo_s & pd_s & ~ctrl_soft_off_q;
         keep_oe_q <= pd_s;
      end
   end
   assign o_pix_oe = pix_oe_q;
   assign o_aux_ctrl_a_oe = keep_oe_q;
   assign o_link_detect_oe = keep_oe_q;

   // ==================================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_odd_low;
      !dual |=> (o_odd_pixel_bus == '0);
   endproperty
   a_odd_low: assert property (p_odd_low) else $error("odd bus not low in single mode");
   property p_single_even;
      upd && !dual && de_s |=> (o_even_pixel_bus == $past(lane_pix));
   endproperty
   a_single_even: assert property (p_single_even) else $error("single mode even bus wrong");
   property p_dual_even;
      upd && dual && de_s |=> (o_even_pixel_bus == $past(even_hold_q));
   endproperty
   a_dual_even: assert property (p_dual_even) else $error("dual mode even bus wrong");
   property p_stagger_sel_n;
      (upd && stagger_sel_n_on) ##1 stagger_sel_n_on[*2] |-> odd_ld;
   endproperty
   a_stagger_sel_n: assert property (p_stagger_sel_n) else $error("staggered odd load not two cycles late");
   property p_nostag;
      upd && dual && !stagger_sel_n_on |=> (o_odd_pixel_bus == $past(odd_src));
   endproperty
   a_nostag: assert property (p_nostag) else $error("odd bus not updated with even");
   property p_link_up;
      de_edge |=> o_link_detect;
   endproperty
   a_link_up: assert property (p_link_up) else $error("link detect not raised on toggle");
   property p_link_down;
      (link_cnt_q == TW'(LINK_TMO - 1)) && !de_edge |=> !o_link_detect;
   endproperty
   a_link_down: assert property (p_link_down) else $error("link detect not dropped at timeout");
   property p_pdo;
      !pdo_s |=> !o_pix_oe && (o_link_detect_oe == $past(pd_s));
   endproperty
   a_pdo: assert property (p_pdo) else $error("output power-down enables wrong");
   property p_ock;
      upd ##1 !upd[*4] |-> (!$past(o_out_pixel_clk, 3) && !o_out_pixel_clk) ##1 o_out_pixel_clk;
   endproperty
   a_ock: assert property (p_ock) else $error("pixel clock low time wrong");
   property p_route;
      upd && !de_s |=> o_ctl.hsync == $past(lane0_s[0]) && o_ctl.aux_a == $past(lane1_s[0])
                       && o_ctl.aux_b == $past(lane2_s[0]);
   endproperty
   a_route: assert property (p_route) else $error("blanking controls misrouted");
   c_single: cover property (upd && !dual && de_s);
   c_stagger_sel_n: cover property (odd_ld && stagger_sel_n_on && de_s);
   c_link_down: cover property ($fell(o_link_detect));
   c_pdo: cover property ($fell(o_pix_oe));
endmodule // tmdsrx_pixel_output

// ### tb/tmdsrx_src_model.sv
// Partner model: upstream transmitter driving decoded lanes and data enable
`timescale 1ns/10ps
module tmdsrx_src_model (
   // Link side outputs
   output logic o_link_clk,
   output logic o_act,
   output logic [7:0] o_lane0,
   output logic [7:0] o_lane1,
   output logic [7:0] o_lane2
);
   // ==================================================
   // Idle state: clock parked low between lines
   initial begin
      o_link_clk = 1'b0;
      o_act = 1'b0;
      {o_lane2, o_lane1, o_lane0} = 24'h00_0000;
   end
   // One link period; lanes change with the rising link clock
   task automatic send(input logic act, input logic [23:0] v);
      o_link_clk <= 1'b1;
      o_act <= act;
      {o_lane2, o_lane1, o_lane0} <= v;
      #400 o_link_clk <= 1'b0;
      #400;
   endtask
   // Released lanes show the inverse so a stale value cannot pass
   task automatic idle();
      {o_lane2, o_lane1, o_lane0} <= ~{o_lane2, o_lane1, o_lane0};
   endtask
endmodule // tmdsrx_src_model

// ### tb/tb.sv
// Testbench: random lines through the pixel output stage, register and power checks
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic [23:0] even;
      logic [23:0] odd;
      logic chk;
      logic [4:0] ctl;
   } tmdsrx_exp_t;
   localparam int unsigned TMO = 120;
   // ==================================================
   // Signals
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic sel = 1'b0;
   logic stagger_sel_n_n = 1'b1;
   logic drv_n = 1'b1;
   logic chip_n = 1'b1;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [3:0] av_a = 4'h0;
   logic [31:0] av_d = 32'h0000_0000;
   logic [3:0] av_be = 4'h0;
   logic link_clk, act, ock, link, pix_oe, a_oe, l_oe, wreq;
   logic [7:0] l0, l1, l2;
   logic [31:0] rdata, rd;
   tmdsrx_pkg::tmdsrx_pix_t even_bus, odd_bus;
   tmdsrx_pkg::tmdsrx_ctl_t ctl;
   logic [31:0] seed = 32'h800f_eb91;
   tmdsrx_exp_t exq[$];
   tmdsrx_exp_t e;
   logic [23:0] held = 24'h00_0000;
   logic phase = 1'b0;
   logic ock_q = 1'b1;
   logic [23:0] odd_q = 24'h00_0000;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   int fall_cyc = 0;
   // ==================================================
   // Clock, design and partner
   always #50 i_core_clk = ~i_core_clk;
   tmdsrx_pixel_output #(.LINK_TMO(TMO)) u_tmdsrx_pixel_output (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_link_clk_in(link_clk),
      .i_lane0_in(l0), .i_lane1_in(l1), .i_lane2_in(l2), .i_video_active_en(act),
      .i_pixels_per_clk_sel(sel), .i_stagger_sel_n(stagger_sel_n_n), .i_out_drive_pwrdn_n(drv_n),
      .i_chip_pwrdn_n(chip_n), .i_reserved_pin(1'b1),
      .o_even_pixel_bus(even_bus), .o_odd_pixel_bus(odd_bus), .o_ctl(ctl),
      .o_out_pixel_clk(ock), .o_link_detect(link), .o_pix_oe(pix_oe),
      .o_aux_ctrl_a_oe(a_oe), .o_link_detect_oe(l_oe), .i_avs_address(av_a),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_d),
      .i_avs_byteenable(av_be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
   tmdsrx_src_model u_tmdsrx_src_model (
      .o_link_clk(link_clk), .o_act(act), .o_lane0(l0), .o_lane1(l1), .o_lane2(l2));
   // ==================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_end(input string s);
      $display("test %0s finished", s);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Avalon access held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge i_core_clk);
      av_rd <= ~wr;
      av_wr <= wr;
      av_a <= a;
      av_d <= d;
      av_be <= be;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      rd = rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (n == 50) check(32'h1, 32'h0);
   endtask
   // One link unit; the expectation is built from the mode rules
   task automatic unit(input logic a, input logic [23:0] v);
      if (!a) exq.push_back({48'h0, 1'b1, 1'b0, v[1], v[0], v[16], v[8]});
      else if (!sel) exq.push_back({v, 24'h0, 6'h0});
      else if (phase) exq.push_back({held, v, 6'h0});
      else held = v;
      phase = a & sel & ~phase;
      u_tmdsrx_src_model.send(a, v);
   endtask
   task automatic line(input int n);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         unit(1'b1, seed[23:0]);
      end
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         unit(1'b0, seed[23:0] & 24'h01_0103);
      end
      u_tmdsrx_src_model.idle();
   endtask
   // ==================================================
   // Monitor: compare at each rising output clock, measure odd bus lag
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      ock_q <= ock;
      odd_q <= odd_bus;
      // Blocking so an odd bus change in the same cycle as the fall sees it
      if (ock_q && !ock) fall_cyc = cyc;
      if (!i_rst && !ock_q && ock) begin
         if (exq.size() == 0) check(32'h1, 32'h0);
         else begin
            e = exq.pop_front();
            check(even_bus, e.even);
            check(odd_bus, e.odd);
            if (e.chk) check(ctl, e.ctl);
         end
      end
      if (!i_rst && sel && odd_bus !== odd_q)
         check(32'(cyc - fall_cyc), stagger_sel_n_n ? 32'h0 : tmdsrx_pkg::STAGGER_SEL_N_LAG_CYC);
   end
   // ==================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_rst <= 1'b0;
      check(ock, 1'b1);
      repeat (5) @(posedge i_core_clk);
      check({pix_oe, a_oe, l_oe, link}, 4'he);
      bus(1'b0, tmdsrx_pkg::CTRL_OFS, 32'h0, 4'hf);
      check(rd, 32'h0);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      check(rd, 32'h0);
      test_end("reset");
      for (int m = 0; m < 3; m++) begin
         sel <= (m != 0);
         stagger_sel_n_n <= (m != 2);
         repeat (6) @(posedge i_core_clk);
         bus(1'b0, tmdsrx_pkg::STATUS_OFS, 32'h0, 4'hf);
         check(rd & 32'h16, 32'h10 | (m == 2 ? 32'h4 : 32'h0) | (m != 0 ? 32'h2 : 32'h0));
         for (int k = 0; k < 2; k++) begin
            line(k ? 8 : 7);
            repeat (30) @(posedge i_core_clk);
            check(32'(exq.size()), 32'h0);
            check(link, 1'b1);
         end
         test_end("mode");
      end
      repeat (TMO + 40) @(posedge i_core_clk);
      check(link, 1'b0);
      bus(1'b1, tmdsrx_pkg::STATUS_OFS, 32'hffff_ffff, 4'hf);
      bus(1'b0, tmdsrx_pkg::STATUS_OFS, 32'h0, 4'hf);
      check(rd, 32'h16);
      test_end("link");
      drv_n <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      check({pix_oe, a_oe, l_oe}, 3'b011);
      chip_n <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      check({pix_oe, a_oe, l_oe}, 3'b000);
      drv_n <= 1'b1;
      chip_n <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      check({pix_oe, a_oe, l_oe}, 3'b111);
      bus(1'b1, tmdsrx_pkg::CTRL_OFS, 32'h1, 4'hf);
      bus(1'b1, tmdsrx_pkg::CTRL_OFS, 32'h0, 4'he);
      bus(1'b0, tmdsrx_pkg::CTRL_OFS, 32'h0, 4'hf);
      check(rd, 32'h1);
      check(pix_oe, 1'b0);
      bus(1'b1, tmdsrx_pkg::CTRL_OFS, 32'h0, 4'hf);
      repeat (3) @(posedge i_core_clk);
      check(pix_oe, 1'b1);
      test_end("power");
      test_done();
   end
   // Watchdog well beyond the expected run of under 100 us
   initial begin
      #500_000;
      mismatches++;
      test_done();
   end
endmodule // tb
